//--- hw/loader_pkg.sv
// Summary of operation
// RULE1: Device holds a 32 KB one-time-programmable store.
// RULE2: Each OTP block accepts programming only once; code takes writes until the block's seal byte is programmed.
// RULE3: Defaults are set first, then OTP is copied.
// RULE4: Device information block loads on every reset.
// RULE5: Strap pins latched at reset select the configuration.
// RULE6: Store holds between two and sixteen configurations; code selects among up to 256 with eight selection pins.
// RULE7: Only stored registers change; others keep defaults.
// RULE8: Bad checksum configuration is not applied at all.
// RULE9: Blocks marked invalid are skipped.
// RULE10: Live register writes never go back to OTP.
// RULE11: OTP is reached only through the controller machine.
// RULE12: Host programs OTP only while device is offline.
// RULE13: First valid EEPROM block loads, then search ends.
// RULE14: EEPROMs probed at 1010xxx, lowest address first.
// RULE15: EEPROM blocks sought only at 0x0000 and 0xF000.
// RULE16: EEPROM block checksum is checked before applying.
// RULE17: Sweep at 1 MHz, then 400 kHz, then 100 kHz.
// RULE18: No selection pins assigned means GPIO 3 to 0.
// RULE19: High EEPROM-disable strap skips all EEPROM reads.
// RULE20: Lowest selection pin index is the least significant bit.
// RULE21: Completion flag rises when all loading stages finish.
package loader_pkg;
   localparam int OTP_BYTES = 32768;
   localparam int OTP_AW = 15;
   localparam int BLK_AW = 8;
   localparam logic [7:0] SEAL_OFFSET = 8'hFF;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   localparam logic [7:0] TYPE_DEVINFO = 8'h01;
   localparam logic [7:0] TYPE_CONFIG = 8'h02;
   localparam logic [7:0] STATUS_VALID = 8'hA5;
   localparam int HDR_LEN = 5;
   localparam int HDR_TYPE = 0;
   localparam int HDR_STATUS = 1;
   localparam int HDR_PARAM = 2;
   localparam int HDR_PARAM2 = 3;
   localparam int HDR_COUNT = 4;
   localparam logic [1:0] REC_LAST = 2'h2;
   localparam logic [7:0] DEFAULT_SEL_MASK = 8'h0F;
   localparam logic [6:0] EE_DEV_FIRST = 7'h50;
   localparam logic [2:0] EE_DEV_LAST = 3'h7;
   localparam logic [15:0] EE_OFFSET0 = 16'h0000;
   localparam logic [15:0] EE_OFFSET1 = 16'hF000;
   localparam logic [1:0] RATE_1MHZ = 2'h0;
   localparam logic [1:0] RATE_400KHZ = 2'h1;
   localparam logic [1:0] RATE_100KHZ = 2'h2;
   localparam logic [1:0] STRAP_SYNC_CYCLES = 2'h2;
   localparam int REC_W = 24;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [3:0] {
      S_DEFAULTS, S_STRAP, S_HDR, S_EVAL, S_VERIFY, S_CHECK, S_APPLY, S_DRAIN,
      S_STAGE_END, S_EE_NEXT, S_DONE, S_PROG_SEAL
   } load_state_t;

   typedef enum logic [1:0] {
      STAGE_DEVINFO, STAGE_OTP_CFG, STAGE_EEPROM
   } load_stage_t;
endpackage : loader_pkg

//--- hw/record_fifo.sv
module record_fifo
   import loader_pkg::*;
#(
   parameter int WIDTH = REC_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("record_fifo depth must be a power of two of at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } fifo_state_t;

   fifo_state_t st_reg;
   fifo_state_t st_next;
   logic push;
   logic load;

   assign in_ready = st_reg.count < (AW+1)'(DEPTH);
   assign out_valid = st_reg.out_valid;
   assign out_data = st_reg.out_data;
   assign empty = (st_reg.count == '0) && !st_reg.out_valid;

   // The output stage is a register, so the storage array never drives a port directly.
   always_comb begin
      st_next = st_reg;
      push = in_valid && in_ready;
      load = (st_reg.count != '0) && (!st_reg.out_valid || out_ready);
      if (out_ready && st_reg.out_valid) begin
         st_next.out_valid = 1'b0;
      end
      if (load) begin
         st_next.out_data = st_reg.mem[st_reg.rd_ptr];
         st_next.out_valid = 1'b1;
         st_next.rd_ptr = st_reg.rd_ptr + AW'(1);
      end
      if (push) begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + AW'(1);
      end
      st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(load);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : record_fifo

//--- hw/otp_eeprom_config_loader.sv
module otp_eeprom_config_loader
   import loader_pkg::*;
#(
   parameter int GPIO_W = 9
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [GPIO_W-1:0] gpio_in,
   output logic otp_rd,
   output logic otp_wr,
   output logic [OTP_AW-1:0] otp_addr,
   output logic [7:0] otp_wdata,
   input wire logic [7:0] otp_rdata,
   input wire logic otp_rvalid,
   output logic ee_rd,
   output logic [6:0] ee_dev_addr,
   output logic [1:0] ee_rate,
   output logic [15:0] ee_addr,
   input wire logic ee_done,
   input wire logic ee_nack,
   input wire logic [7:0] ee_rdata,
   output logic img_defaults,
   output logic img_valid,
   input wire logic img_ready,
   output logic [15:0] img_addr,
   output logic [7:0] img_data,
   input wire logic prog_req,
   input wire logic [OTP_AW-1:0] prog_addr,
   input wire logic [7:0] prog_data,
   output logic prog_done,
   output logic prog_refused,
   output logic load_done,
   output logic cfg_loaded,
   output logic cfg_error,
   output logic [7:0] cfg_number,
   output logic ee_loaded
);
   generate
      if (GPIO_W < 8) begin : g_bad_gpio
         $error("otp_eeprom_config_loader needs at least eight strap pins");
      end
   endgenerate

   typedef struct packed {
      load_state_t state;
      load_stage_t stage;
      logic [GPIO_W-1:0] gpio_meta;
      logic [GPIO_W-1:0] gpio_sync;
      logic [GPIO_W-1:0] strap;
      logic [1:0] sync_cnt;
      logic [7:0] sel_mask;
      logic [7:0] dis_mask;
      logic [7:0] sel_num;
      logic [15:0] base;
      logic [9:0] idx;
      logic [1:0] rec_pos;
      logic [15:0] rec;
      logic [7:0] hdr_type;
      logic [7:0] hdr_status;
      logic [7:0] hdr_param;
      logic [7:0] hdr_param2;
      logic [7:0] hdr_count;
      logic [7:0] sum;
      logic rd_pending;
      logic push;
      logic [REC_W-1:0] push_data;
      logic otp_rd;
      logic otp_wr;
      logic [OTP_AW-1:0] otp_addr;
      logic [7:0] otp_wdata;
      logic ee_rd;
      logic [6:0] ee_dev_addr;
      logic [1:0] ee_rate;
      logic [15:0] ee_addr;
      logic ee_off_hi;
      logic ee_seen;
      logic ee_absent;
      logic img_defaults;
      logic prog_done;
      logic prog_refused;
      logic [OTP_AW-1:0] prog_addr;
      logic [7:0] prog_data;
      logic load_done;
      logic cfg_loaded;
      logic cfg_error;
      logic ee_loaded;
   } loader_state_t;

   loader_state_t st;
   loader_state_t n;
   logic fifo_ready;
   logic fifo_empty;
   logic src_ee;
   logic rsp;
   logic [7:0] rsp_byte;
   logic rsp_nack;
   logic [15:0] blk_len;
   logic [15:0] rd_addr;
   logic last_byte;
   logic ee_off;
   logic [7:0] sel_mask_eff;
   logic [7:0] sel_pack;
   logic [2:0] sel_bit;

   assign src_ee = (st.stage == STAGE_EEPROM) && (st.state != S_PROG_SEAL);
   assign rsp = st.rd_pending && (src_ee ? ee_done : otp_rvalid);
   assign rsp_byte = src_ee ? ee_rdata : otp_rdata;
   assign rsp_nack = src_ee && ee_nack;
   assign blk_len = 16'(HDR_LEN + 1) + 16'(st.hdr_count) * 16'h0003;
   assign rd_addr = st.base + {6'h00, st.idx};
   assign last_byte = ({6'h00, st.idx} == blk_len - 16'h0001);
   assign ee_off = |(st.strap[7:0] & st.dis_mask); // [RULE19]
   assign sel_mask_eff = (st.sel_mask == 8'h00) ? DEFAULT_SEL_MASK : st.sel_mask; // [RULE18]

   // Selected pins are packed in index order, so gaps in the mask do not leave gaps in the number.
   always_comb begin
      sel_pack = 8'h00;
      sel_bit = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (sel_mask_eff[i]) begin
            sel_pack[sel_bit] = st.strap[i]; // [RULE20]
            sel_bit = sel_bit + 3'h1;
         end
      end
   end

   always_comb begin
      n = st;
      n.gpio_meta = gpio_in;
      n.gpio_sync = st.gpio_meta;
      n.otp_rd = 1'b0;
      n.otp_wr = 1'b0;
      n.ee_rd = 1'b0;
      n.img_defaults = 1'b0;
      n.prog_done = 1'b0;
      n.prog_refused = 1'b0;
      if (st.push && fifo_ready) begin
         n.push = 1'b0;
      end
      if (prog_req && st.state != S_DONE) begin
         n.prog_refused = 1'b1; // [RULE12]
      end
      if (rsp) begin
         n.rd_pending = 1'b0;
         if (!rsp_nack) begin
            n.ee_seen = n.ee_seen | src_ee; // [RULE17]
         end
      end
      case (st.state)
         S_DEFAULTS: begin
            n.state = S_STRAP; // [RULE3]
         end
         S_STRAP: begin
            if (st.sync_cnt == STRAP_SYNC_CYCLES) begin
               n.strap = st.gpio_sync; // [RULE5]
               n.stage = STAGE_DEVINFO; // [RULE4]
               n.base = 16'h0000;
               n.idx = 10'h000;
               n.sum = 8'h00;
               n.state = S_HDR;
            end else begin
               n.sync_cnt = st.sync_cnt + 2'h1;
            end
         end
         S_HDR: begin
            if (!src_ee && st.idx == 10'h000 && st.base > 16'(OTP_BYTES - HDR_LEN)) begin
               n.state = S_STAGE_END; // [RULE1]
            end else if (rsp && rsp_nack) begin
               n.ee_absent = 1'b1;
               n.state = S_EE_NEXT;
            end else if (rsp) begin
               case (st.idx[2:0])
                  3'(HDR_TYPE): n.hdr_type = rsp_byte;
                  3'(HDR_STATUS): n.hdr_status = rsp_byte;
                  3'(HDR_PARAM): n.hdr_param = rsp_byte;
                  3'(HDR_PARAM2): n.hdr_param2 = rsp_byte;
                  default: n.hdr_count = rsp_byte;
               endcase
               n.sum = st.sum + rsp_byte;
               n.idx = st.idx + 10'h001;
               if (st.idx == 10'(HDR_COUNT)) begin
                  n.state = S_EVAL;
               end
            end
         end
         S_EVAL: begin
            if (st.hdr_type == BLANK_BYTE) begin
               n.state = src_ee ? S_EE_NEXT : S_STAGE_END;
            end else if (st.hdr_status == STATUS_VALID && // [RULE9]
                  ((st.stage == STAGE_DEVINFO && st.hdr_type == TYPE_DEVINFO) ||
                   (st.stage == STAGE_OTP_CFG && st.hdr_type == TYPE_CONFIG &&
                    st.hdr_param == st.sel_num) || // [RULE5] [RULE6]
                   (st.stage == STAGE_EEPROM && st.hdr_type == TYPE_CONFIG))) begin
               n.state = S_VERIFY;
            end else if (src_ee) begin
               n.state = S_EE_NEXT; // [RULE15]
            end else begin
               n.base = st.base + blk_len;
               n.idx = 10'h000;
               n.sum = 8'h00;
               n.state = S_HDR;
            end
         end
         S_VERIFY: begin
            if (rsp && rsp_nack) begin
               n.state = S_EE_NEXT;
            end else if (rsp) begin
               n.sum = st.sum + rsp_byte;
               n.idx = st.idx + 10'h001;
               if (last_byte) begin
                  n.state = S_CHECK;
               end
            end
         end
         S_CHECK: begin
            // A block is read twice so that nothing reaches the image before its sum is known good.
            if (st.sum == 8'h00) begin
               n.idx = 10'(HDR_LEN); // [RULE16]
               n.rec_pos = 2'h0;
               n.state = S_APPLY;
            end else if (src_ee) begin
               n.state = S_EE_NEXT;
            end else begin
               n.cfg_error = n.cfg_error | (st.stage == STAGE_OTP_CFG); // [RULE8]
               n.state = S_STAGE_END;
            end
         end
         S_APPLY: begin
            if (rsp) begin
               n.idx = st.idx + 10'h001;
               if (st.rec_pos == REC_LAST) begin
                  n.push = 1'b1; // [RULE7]
                  n.push_data = {st.rec, rsp_byte};
                  n.rec_pos = 2'h0;
               end else begin
                  n.rec = {st.rec[7:0], rsp_byte};
                  n.rec_pos = st.rec_pos + 2'h1;
               end
            end else if (!st.rd_pending && !st.push && last_byte) begin
               n.state = S_DRAIN;
            end
         end
         S_DRAIN: begin
            if (!st.push && fifo_empty) begin
               if (st.stage == STAGE_DEVINFO) begin
                  n.sel_mask = st.hdr_param;
                  n.dis_mask = st.hdr_param2;
               end else if (st.stage == STAGE_OTP_CFG) begin
                  n.cfg_loaded = 1'b1;
               end else begin
                  n.ee_loaded = 1'b1;
               end
               n.state = (st.stage == STAGE_EEPROM) ? S_DONE : S_STAGE_END; // [RULE13]
            end
         end
         S_STAGE_END: begin
            n.idx = 10'h000;
            n.sum = 8'h00;
            if (st.stage == STAGE_DEVINFO) begin
               n.sel_num = sel_pack;
               n.stage = STAGE_OTP_CFG;
               n.base = 16'h0000;
               n.state = S_HDR;
            end else if (st.stage == STAGE_OTP_CFG && !ee_off) begin
               n.stage = STAGE_EEPROM;
               n.ee_dev_addr = EE_DEV_FIRST; // [RULE14]
               n.ee_rate = RATE_1MHZ; // [RULE17]
               n.ee_off_hi = 1'b0;
               n.ee_seen = 1'b0;
               n.ee_absent = 1'b0;
               n.base = EE_OFFSET0;
               n.state = S_HDR;
            end else begin
               n.state = S_DONE;
            end
         end
         S_EE_NEXT: begin
            n.idx = 10'h000;
            n.sum = 8'h00;
            n.ee_absent = 1'b0;
            n.state = S_HDR;
            if (!st.ee_absent && !st.ee_off_hi) begin
               n.ee_off_hi = 1'b1;
               n.base = EE_OFFSET1; // [RULE15]
            end else begin
               n.ee_off_hi = 1'b0;
               n.base = EE_OFFSET0;
               if (st.ee_dev_addr[2:0] != EE_DEV_LAST) begin
                  n.ee_dev_addr = st.ee_dev_addr + 7'h01; // [RULE14]
               end else if (!st.ee_seen && st.ee_rate != RATE_100KHZ) begin
                  n.ee_dev_addr = EE_DEV_FIRST;
                  n.ee_rate = (st.ee_rate == RATE_1MHZ) ? RATE_400KHZ : RATE_100KHZ; // [RULE17]
               end else begin
                  n.state = S_DONE;
               end
            end
         end
         S_DONE: begin
            n.load_done = 1'b1; // [RULE21]
            if (prog_req) begin
               n.prog_addr = prog_addr; // [RULE11]
               n.prog_data = prog_data;
               n.state = S_PROG_SEAL;
            end
         end
         S_PROG_SEAL: begin
            // The last byte of each block is its seal; once programmed the block takes no more writes.
            if (rsp) begin
               n.state = S_DONE;
               if (rsp_byte != BLANK_BYTE) begin
                  n.prog_refused = 1'b1; // [RULE2]
               end else begin
                  n.otp_wr = 1'b1; // [RULE10]
                  n.otp_addr = st.prog_addr;
                  n.otp_wdata = st.prog_data;
                  n.prog_done = 1'b1;
               end
            end
         end
         default: begin
            n.state = S_DONE;
         end
      endcase
      if (!st.rd_pending && !st.push && !rsp) begin
         // Verification must also fetch the checksum byte, so it reads up to and including the last index.
         if ((st.state == S_HDR && n.state == S_HDR) || st.state == S_VERIFY ||
               (st.state == S_APPLY && !last_byte)) begin
            n.rd_pending = 1'b1;
            if (src_ee) begin
               n.ee_rd = 1'b1;
               n.ee_addr = rd_addr;
            end else begin
               n.otp_rd = 1'b1;
               n.otp_addr = rd_addr[OTP_AW-1:0];
            end
         end else if (st.state == S_PROG_SEAL) begin
            n.rd_pending = 1'b1;
            n.otp_rd = 1'b1;
            n.otp_addr = {st.prog_addr[OTP_AW-1:BLK_AW], SEAL_OFFSET};
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.img_defaults <= 1'b1;
      end else begin
         st <= n;
      end
   end

   record_fifo #(
      .WIDTH(REC_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(st.push),
      .in_ready(fifo_ready),
      .in_data(st.push_data),
      .out_valid(img_valid),
      .out_ready(img_ready),
      .out_data({img_addr, img_data}),
      .empty(fifo_empty)
   );

   assign otp_rd = st.otp_rd;
   assign otp_wr = st.otp_wr;
   assign otp_addr = st.otp_addr;
   assign otp_wdata = st.otp_wdata;
   assign ee_rd = st.ee_rd;
   assign ee_dev_addr = st.ee_dev_addr;
   assign ee_rate = st.ee_rate;
   assign ee_addr = st.ee_addr;
   assign img_defaults = st.img_defaults;
   assign prog_done = st.prog_done;
   assign prog_refused = st.prog_refused;
   assign load_done = st.load_done;
   assign cfg_loaded = st.cfg_loaded;
   assign cfg_error = st.cfg_error;
   assign cfg_number = st.sel_num;
   assign ee_loaded = st.ee_loaded;

   a_defaults_then_strap: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
      st.img_defaults |=> st.state == S_STRAP && !st.push && !img_valid)
      else $error("defaults pulse not followed by strap wait");
   a_devinfo_first: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
      (st.state == S_STRAP && st.sync_cnt == STRAP_SYNC_CYCLES) |=> st.stage == STAGE_DEVINFO && st.state == S_HDR)
      else $error("device information stage not entered after strap latch");
   a_seal_refuses: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
      (st.state == S_PROG_SEAL && rsp && rsp_byte != BLANK_BYTE) |=> st.prog_refused && !st.otp_wr)
      else $error("write to sealed block not refused");
   a_default_select: assert property (@(posedge clk) disable iff (!resetn) // [RULE18]
      (st.state == S_STAGE_END && st.stage == STAGE_DEVINFO && st.sel_mask == 8'h00)
      |=> st.sel_num == {4'h0, st.strap[3:0]})
      else $error("default selection pins not used");
   a_cfg_number_match: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
      (st.state == S_EVAL && st.stage == STAGE_OTP_CFG && st.hdr_param != st.sel_num) |=> st.state != S_VERIFY)
      else $error("unselected configuration accepted");
   a_bad_sum_blocks: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
      (st.state == S_CHECK && st.sum != 8'h00) |=> st.state != S_APPLY ##1 !st.push)
      else $error("block with bad checksum applied");
   a_invalid_skipped: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
      (st.state == S_EVAL && st.hdr_status != STATUS_VALID) |=> st.state != S_VERIFY)
      else $error("invalidated block not skipped");
   a_ee_offsets: assert property (@(posedge clk) disable iff (!resetn) // [RULE15]
      (st.ee_rd && st.idx == 10'h000) |-> st.ee_addr == EE_OFFSET0 || st.ee_addr == EE_OFFSET1)
      else $error("EEPROM block sought at wrong offset");
   a_ee_disabled: assert property (@(posedge clk) disable iff (!resetn) // [RULE19]
      (st.stage == STAGE_EEPROM) |-> !ee_off)
      else $error("EEPROM searched while disabled");
   a_dev_step: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
      (st.state == S_EE_NEXT && st.ee_absent && st.ee_dev_addr[2:0] != EE_DEV_LAST)
      |=> st.ee_dev_addr == $past(st.ee_dev_addr) + 7'h01)
      else $error("EEPROM address did not step upward");
   a_ee_stop_first: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
      (st.state == S_DRAIN && st.stage == STAGE_EEPROM && !st.push && fifo_empty) |=> st.state == S_DONE)
      else $error("EEPROM search continued after a valid block");
   a_done_sticks: assert property (@(posedge clk) disable iff (!resetn) // [RULE21]
      st.load_done |=> st.load_done && !img_valid [*2])
      else $error("completion flag dropped or image written after completion");
endmodule : otp_eeprom_config_loader

//--- sim/far_side.sv
module far_side
   import loader_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic otp_rd,
   input wire logic otp_wr,
   input wire logic [OTP_AW-1:0] otp_addr,
   input wire logic [7:0] otp_wdata,
   output logic [7:0] otp_rdata,
   output logic otp_rvalid,
   input wire logic ee_rd,
   input wire logic [6:0] ee_dev_addr,
   input wire logic [1:0] ee_rate,
   input wire logic [15:0] ee_addr,
   output logic ee_done,
   output logic ee_nack,
   output logic [7:0] ee_rdata,
   input wire logic img_valid,
   input wire logic [15:0] img_addr,
   input wire logic [7:0] img_data,
   output logic img_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:OTP_BYTES-1];
   logic [1:0] rd_pipe = 2'h0;
   logic [7:0] tick = 8'h00;
   int n_img;
   int n_ee;
   logic [15:0] last_addr;
   logic [7:0] last_data;
   logic [6:0] last_dev;
   logic [1:0] last_rate;
   logic [15:0] last_ee;
   initial begin
      foreach (mem[i]) mem[i] = BLANK_BYTE;
      {otp_rdata, otp_rvalid, ee_done, ee_nack, ee_rdata, img_ready} = '0;
   end
   // The sink stalls every third cycle so backpressure reaches the FIFO; idle data changes every cycle.
   always @(negedge clk) begin
      tick <= tick + 8'h01;
      img_ready <= (tick % 3) != 0;
      rd_pipe <= resetn ? {rd_pipe[0], otp_rd} : 2'h0;
      otp_rvalid <= rd_pipe[1];
      otp_rdata <= rd_pipe[1] ? mem[otp_addr] : ~otp_rdata;
      ee_done <= ee_rd;
      // No memory is fitted on the serial bus, so every probe goes unanswered.
      ee_nack <= 1'b1;
      ee_rdata <= tick;
   end
   always @(posedge clk) begin
      if (!resetn) begin
         n_img = 0;
         n_ee = 0;
      end
      if (otp_wr) mem[otp_addr] <= otp_wdata;
      if (img_valid && img_ready) begin
         n_img++;
         last_addr = img_addr;
         last_data = img_data;
      end
      if (ee_rd) begin
         n_ee++;
         last_dev = ee_dev_addr;
         last_rate = ee_rate;
         last_ee = ee_addr;
      end
   end
endmodule : far_side

//--- sim/tb_top.sv
module tb_top
   import loader_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [8:0] gpio; logic [7:0] num; logic ok; logic err; int imgs;} row_t;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [8:0] gpio_in = 9'h000;
   logic prog_req = 1'b0;
   logic [OTP_AW-1:0] prog_addr = '0;
   logic [7:0] prog_data = 8'h00;
   logic otp_rd, otp_wr, otp_rvalid, ee_rd, ee_done, ee_nack, img_defaults, img_valid, img_ready;
   logic prog_done, prog_refused, load_done, cfg_loaded, cfg_error, ee_loaded;
   logic [OTP_AW-1:0] otp_addr;
   logic [7:0] otp_wdata, otp_rdata, ee_rdata, img_data, cfg_number;
   logic [6:0] ee_dev_addr;
   logic [1:0] ee_rate;
   logic [15:0] img_addr, ee_addr;
   int n_mismatch = 0;
   int total_checks = 0;
   // Devinfo, an invalidated config 3, a good config 3, then config 5 with a broken checksum.
   logic [7:0] otp_img [30] = '{8'h01, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h5A,
      8'h02, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h10, 8'h44, 8'hA6,
      8'h02, 8'hA5, 8'h03, 8'h00, 8'h01, 8'h00, 8'h10, 8'h33, 8'h12,
      8'h02, 8'hA5, 8'h05, 8'h00, 8'h00, 8'h55};
   row_t rows [4] = '{'{9'h003, 8'h03, 1'b1, 1'b0, 1}, '{9'h1F3, 8'h03, 1'b1, 1'b0, 1},
      '{9'h005, 8'h05, 1'b0, 1'b1, 0}, '{9'h007, 8'h07, 1'b0, 1'b0, 0}};

   always #25 clk = ~clk;

   otp_eeprom_config_loader dut_u (.clk, .resetn, .gpio_in, .otp_rd, .otp_wr, .otp_addr, .otp_wdata,
      .otp_rdata, .otp_rvalid, .ee_rd, .ee_dev_addr, .ee_rate, .ee_addr, .ee_done, .ee_nack, .ee_rdata,
      .img_defaults, .img_valid, .img_ready, .img_addr, .img_data, .prog_req, .prog_addr, .prog_data,
      .prog_done, .prog_refused, .load_done, .cfg_loaded, .cfg_error, .cfg_number, .ee_loaded);
   far_side far_u (.clk, .resetn, .otp_rd, .otp_wr, .otp_addr, .otp_wdata, .otp_rdata, .otp_rvalid,
      .ee_rd, .ee_dev_addr, .ee_rate, .ee_addr, .ee_done, .ee_nack, .ee_rdata, .img_valid, .img_addr, .img_data,
      .img_ready);

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out

   task boot(input logic [8:0] g);
      int i;
      resetn = 1'b0;
      gpio_in = g;
      repeat (5) @(negedge clk);
      chk("img_defaults", 16'h0001, {15'h0000, img_defaults});
      resetn = 1'b1;
      for (i = 0; i < 3000 && load_done !== 1'b1; i++) @(negedge clk);
      if (i == 3000) begin
         chk("load_done", 16'h0001, {15'h0000, load_done});
         close_out();
      end
   endtask : boot

   // Waits on either answer pulse; both are one cycle wide, so sampling between edges sees them.
   task prog(input logic [14:0] a, input logic [7:0] d, input logic exp_done);
      int i;
      prog_addr = a;
      prog_data = d;
      prog_req = 1'b1;
      @(negedge clk);
      prog_req = 1'b0;
      for (i = 0; i < 50 && prog_done !== 1'b1 && prog_refused !== 1'b1; i++) @(negedge clk);
      chk("prog_done", {15'h0000, exp_done}, {15'h0000, prog_done});
      chk("prog_refused", {15'h0000, !exp_done}, {15'h0000, prog_refused});
      // The program strobe reaches the memory one edge after the answer, so let that edge pass.
      @(negedge clk);
   endtask : prog

   initial begin
      @(negedge clk);
      foreach (otp_img[i]) far_u.mem[i] = otp_img[i];
      foreach (rows[r]) begin
         boot(rows[r].gpio);
         chk("cfg_number", {8'h00, rows[r].num}, {8'h00, cfg_number});
         chk("cfg_loaded", {15'h0000, rows[r].ok}, {15'h0000, cfg_loaded});
         chk("cfg_error", {15'h0000, rows[r].err}, {15'h0000, cfg_error});
         chk("image writes", 16'(rows[r].imgs), 16'(far_u.n_img));
         if (rows[r].ok) begin
            chk("image addr", 16'h0010, far_u.last_addr);
            chk("image data", 16'h0033, {8'h00, far_u.last_data});
         end
         $display("row %0d done", r);
      end
      chk("probes", 16'd24, 16'(far_u.n_ee));
      chk("last device", 16'h0057, {9'h000, far_u.last_dev});
      chk("last rate", {14'h0000, RATE_100KHZ}, {14'h0000, far_u.last_rate});
      chk("last offset", EE_OFFSET0, far_u.last_ee);
      chk("ee_loaded", 16'h0000, {15'h0000, ee_loaded});
      chk("load_done", 16'h0001, {15'h0000, load_done});
      $display("sweep test done");
      // Device information now routes pins 1 and 4 to the selection and pin 7 to the EEPROM disable.
      {far_u.mem[2], far_u.mem[3], far_u.mem[5]} = {8'h12, 8'h80, 8'hC8};
      boot(9'h092);
      chk("masked number", 16'h0003, {8'h00, cfg_number});
      chk("masked cfg_loaded", 16'h0001, {15'h0000, cfg_loaded});
      chk("probes disabled", 16'h0000, 16'(far_u.n_ee));
      $display("strap mask test done");
      prog(15'h0100, 8'h12, 1'b1);
      chk("otp byte", 16'h0012, {8'h00, far_u.mem[256]});
      prog(15'h01FF, 8'h00, 1'b1);
      prog(15'h0180, 8'h34, 1'b0);
      chk("sealed byte", 16'h00FF, {8'h00, far_u.mem[384]});
      resetn = 1'b0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      prog(15'h0200, 8'h01, 1'b0);
      $display("program test done");
      close_out();
   end
endmodule : tb_top
